// >>> design/clock_config_pkg.sv
// constants shared by the clock select and output configuration bank
// assumes a single device clock; offsets are the register addresses
package clock_config_pkg;

  localparam logic [7:0] OFF_FREE_RUN_CTRL  = 8'h00;
  localparam logic [7:0] OFF_PRIORITY       = 8'h01;
  localparam logic [7:0] OFF_BANDWIDTH      = 8'h02;
  localparam logic [7:0] OFF_PICK_HOLD      = 8'h03;
  localparam logic [7:0] OFF_METHOD_HISTORY = 8'h04;
  localparam logic [7:0] OFF_DRIVE_FORMAT   = 8'h05;

  localparam logic [7:0] RESET_FREE_RUN_CTRL  = 8'h14;
  localparam logic [7:0] RESET_PRIORITY       = 8'hE4;
  localparam logic [7:0] RESET_BANDWIDTH      = 8'h42;
  localparam logic [7:0] RESET_PICK_HOLD      = 8'h05;
  localparam logic [7:0] RESET_METHOD_HISTORY = 8'h12;
  localparam logic [7:0] RESET_DRIVE_FORMAT   = 8'hED;

  // writable bits; all others keep their reset value
  localparam logic [7:0] MASK_FREE_RUN_CTRL  = 8'h62;
  localparam logic [7:0] MASK_PRIORITY       = 8'hFF;
  localparam logic [7:0] MASK_BANDWIDTH      = 8'hF0;
  localparam logic [7:0] MASK_PICK_HOLD      = 8'hF0;
  localparam logic [7:0] MASK_METHOD_HISTORY = 8'hDF;
  localparam logic [7:0] MASK_DRIVE_FORMAT   = 8'hFF;

  localparam int UNMUTED_OVERRIDE_BIT = 5;
  localparam int BANDWIDTH_LSB        = 4;
  localparam int INPUT_PICK_LSB       = 6;
  localparam int FORCE_HOLDOVER_BIT   = 5;
  localparam int MUTE_CAL_BIT         = 4;
  localparam int METHOD_LSB           = 6;
  localparam int HISTORY_LSB          = 0;
  localparam int DRIVE_LSB            = 6;
  localparam int OUT2_FORMAT_LSB      = 3;
  localparam int OUT1_FORMAT_LSB      = 0;

  localparam logic [1:0] METHOD_MANUAL        = 2'h0;
  localparam logic [1:0] METHOD_AUTO_NONREVERT = 2'h1;
  localparam logic [1:0] METHOD_AUTO_REVERT    = 2'h2;

  localparam logic [2:0] FORMAT_DISABLED  = 3'h1;
  localparam logic [2:0] FORMAT_CMOS      = 3'h2;
  localparam logic [2:0] FORMAT_LOW_LVDS  = 3'h3;
  localparam logic [2:0] FORMAT_LVPECL    = 3'h5;
  localparam logic [2:0] FORMAT_CML       = 3'h6;
  localparam logic [2:0] FORMAT_LVDS      = 3'h7;

  localparam int CAL_CYCLES = 16;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_RUN  = 2'b10
  } cal_state_type;

endpackage

// >>> design/input_selector.sv
// next active input and holdover decision, purely combinational
// assumes all inputs are already on the device clock
module input_selector (
  input  wire logic [1:0] selectionMethod,
  input  wire logic       forceHoldover,
  input  wire logic       pickByPinsFlag,
  input  wire logic [1:0] inputPickPins,
  input  wire logic [1:0] inputPickField,
  input  wire logic [7:0] prioritySlots,
  input  wire logic [3:0] inputGood,
  input  wire logic [1:0] currentInput,
  input  wire logic       currentHold,
  output logic      [1:0] next_input,
  output logic            next_hold
);

  logic [1:0] bestInput;
  logic       bestFound;

  // slot 0 searched last so it wins
  always_comb
  begin
    bestInput = currentInput;
    bestFound = 1'b0;
    for (int slot = 3; slot >= 0; slot--)
    begin
      if (inputGood[prioritySlots[2*slot +: 2]])
      begin
        bestInput = prioritySlots[2*slot +: 2];
        bestFound = 1'b1;
      end
    end
  end

  always_comb
  begin
    next_input = currentInput;
    next_hold  = 1'b0;
    if (forceHoldover)
      next_hold = 1'b1;
    else if (selectionMethod == clock_config_pkg::METHOD_MANUAL)
    begin
      if (pickByPinsFlag)
        next_input = inputPickPins;
      else
        next_input = inputPickField;
    end
    else if (selectionMethod == clock_config_pkg::METHOD_AUTO_REVERT)
    begin
      next_input = bestInput;
      next_hold  = !bestFound;
    end
    else if (selectionMethod == clock_config_pkg::METHOD_AUTO_NONREVERT)
    begin
      if (!currentHold && inputGood[currentInput])
        next_input = currentInput;
      else
      begin
        next_input = bestInput;
        next_hold  = !bestFound;
      end
    end
    else
      next_hold = currentHold; // reserved method: freeze
  end

endmodule

// >>> design/clock_config_regs.sv
// clock select and output configuration register bank
// assumes register port behind the serial interface, device clock only
//
// Function
// - bandwidth code applied only at next calibration
// - manual mode: register field picks input
// - manual mode, pin flag set: pins pick input
// - force holdover overrides all selection
// - mute bit squelches outputs during calibration
// - decode manual, non-revertive, revertive methods
// - history delay field drives holdover history
// - drive strength field sets CMOS drive
// - decode output format codes per output
// - registers reset to documented values
// - unmuted override keeps outputs driven
// - automatic modes rank inputs by priority
module clock_config_regs #(
  parameter int CAL_CYCLES = clock_config_pkg::CAL_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrite,
  input  wire logic [7:0] regWriteData,
  input  wire logic       regRead,
  output logic      [7:0] regReadData,
  input  wire logic       calStart,
  input  wire logic       pickByPinsPin,
  input  wire logic [1:0] inputPickPins,
  input  wire logic [3:0] inputGood,
  output logic      [3:0] activeBandwidth,
  output logic            calRunning,
  output logic            outputsOn,
  output logic      [1:0] activeInput,
  output logic            inHoldover,
  output logic      [4:0] historyDelay,
  output logic      [1:0] cmosDrive,
  output logic      [2:0] out1Format,
  output logic      [2:0] out2Format,
  output logic            out1Enabled,
  output logic            out2Enabled,
  output logic            out1Cmos,
  output logic            out2Cmos
);

  logic [7:0] freeRunCtrl;
  logic [7:0] prioritySlots;
  logic [7:0] bandwidthReg;
  logic [7:0] pickHoldReg;
  logic [7:0] methodHistReg;
  logic [7:0] driveFormatReg;

  logic [2:0] pinSync1;
  logic [2:0] pinSync2;
  logic [2:0] pinSync3;
  logic [2:0] pinStable;

  clock_config_pkg::cal_state_type calState;
  logic [7:0]                      calCount;
  logic                            calibrated;

  logic [1:0] next_input;
  logic       next_hold;

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] mask);
    return (old & ~mask) | (regWriteData & mask);
  endfunction

  function automatic logic format_on(input logic [2:0] fmt);
    return fmt == clock_config_pkg::FORMAT_CMOS || fmt == clock_config_pkg::FORMAT_LOW_LVDS ||
           fmt == clock_config_pkg::FORMAT_LVPECL || fmt == clock_config_pkg::FORMAT_CML ||
           fmt == clock_config_pkg::FORMAT_LVDS;
  endfunction

  // masked writes keep reserved bits at reset value
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      freeRunCtrl    <= clock_config_pkg::RESET_FREE_RUN_CTRL;
      prioritySlots  <= clock_config_pkg::RESET_PRIORITY;
      bandwidthReg   <= clock_config_pkg::RESET_BANDWIDTH;
      pickHoldReg    <= clock_config_pkg::RESET_PICK_HOLD;
      methodHistReg  <= clock_config_pkg::RESET_METHOD_HISTORY;
      driveFormatReg <= clock_config_pkg::RESET_DRIVE_FORMAT;
    end
    else if (regWrite)
    begin
      if (regAddr == clock_config_pkg::OFF_FREE_RUN_CTRL)
        freeRunCtrl <= merge(freeRunCtrl, clock_config_pkg::MASK_FREE_RUN_CTRL);
      else if (regAddr == clock_config_pkg::OFF_PRIORITY)
        prioritySlots <= merge(prioritySlots, clock_config_pkg::MASK_PRIORITY);
      else if (regAddr == clock_config_pkg::OFF_BANDWIDTH)
        bandwidthReg <= merge(bandwidthReg, clock_config_pkg::MASK_BANDWIDTH);
      else if (regAddr == clock_config_pkg::OFF_PICK_HOLD)
        pickHoldReg <= merge(pickHoldReg, clock_config_pkg::MASK_PICK_HOLD);
      else if (regAddr == clock_config_pkg::OFF_METHOD_HISTORY)
        methodHistReg <= merge(methodHistReg, clock_config_pkg::MASK_METHOD_HISTORY);
      else if (regAddr == clock_config_pkg::OFF_DRIVE_FORMAT)
        driveFormatReg <= merge(driveFormatReg, clock_config_pkg::MASK_DRIVE_FORMAT);
    end
  end

  // unmapped addresses read zero
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      regReadData <= 8'h00;
    else if (regRead)
    begin
      if (regAddr == clock_config_pkg::OFF_FREE_RUN_CTRL)
        regReadData <= freeRunCtrl;
      else if (regAddr == clock_config_pkg::OFF_PRIORITY)
        regReadData <= prioritySlots;
      else if (regAddr == clock_config_pkg::OFF_BANDWIDTH)
        regReadData <= bandwidthReg;
      else if (regAddr == clock_config_pkg::OFF_PICK_HOLD)
        regReadData <= pickHoldReg;
      else if (regAddr == clock_config_pkg::OFF_METHOD_HISTORY)
        regReadData <= methodHistReg;
      else if (regAddr == clock_config_pkg::OFF_DRIVE_FORMAT)
        regReadData <= driveFormatReg;
      else
        regReadData <= 8'h00;
    end
  end

  // three-stage pin sync, change taken when stages two and three agree
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pinSync1  <= 3'h0;
      pinSync2  <= 3'h0;
      pinSync3  <= 3'h0;
      pinStable <= 3'h0;
    end
    else
    begin
      pinSync1 <= {pickByPinsPin, inputPickPins};
      pinSync2 <= pinSync1;
      pinSync3 <= pinSync2;
      for (int i = 0; i < 3; i++)
        if (pinSync2[i] == pinSync3[i])
          pinStable[i] <= pinSync3[i];
    end
  end

  // a start while running is ignored; code latched only at start
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      calState        <= clock_config_pkg::CAL_IDLE;
      calCount        <= 8'h00;
      calibrated      <= 1'b0;
      activeBandwidth <= clock_config_pkg::RESET_BANDWIDTH[7:4];
    end
    else
    begin
      case (calState)
        clock_config_pkg::CAL_IDLE:
          if (calStart)
          begin
            activeBandwidth <= bandwidthReg[clock_config_pkg::BANDWIDTH_LSB +: 4];
            calCount        <= 8'(CAL_CYCLES - 1);
            calState        <= clock_config_pkg::CAL_RUN;
          end
        clock_config_pkg::CAL_RUN:
          if (calCount == 8'h00)
          begin
            calibrated <= 1'b1;
            calState   <= clock_config_pkg::CAL_IDLE;
          end
          else
            calCount <= calCount - 8'h01;
        default:
          calState <= clock_config_pkg::CAL_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      calRunning <= 1'b0;
      outputsOn  <= 1'b0;
    end
    else
    begin
      calRunning <= calState == clock_config_pkg::CAL_RUN;
      // squelch also before the first calibration, unless overridden
      outputsOn <= freeRunCtrl[clock_config_pkg::UNMUTED_OVERRIDE_BIT] ||
                   !(pickHoldReg[clock_config_pkg::MUTE_CAL_BIT] &&
                     (calState == clock_config_pkg::CAL_RUN || !calibrated));
    end
  end

  input_selector selector (
    .selectionMethod (methodHistReg[clock_config_pkg::METHOD_LSB +: 2]),
    .forceHoldover   (pickHoldReg[clock_config_pkg::FORCE_HOLDOVER_BIT]),
    .pickByPinsFlag  (pinStable[2]),
    .inputPickPins   (pinStable[1:0]),
    .inputPickField  (pickHoldReg[clock_config_pkg::INPUT_PICK_LSB +: 2]),
    .prioritySlots   (prioritySlots),
    .inputGood       (inputGood),
    .currentInput    (activeInput),
    .currentHold     (inHoldover),
    .next_input      (next_input),
    .next_hold       (next_hold)
  );

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      activeInput <= 2'h0;
      inHoldover  <= 1'b0;
    end
    else
    begin
      activeInput <= next_input;
      inHoldover  <= next_hold;
    end
  end

  // software owns the LVPECL/CMOS power budget; no check here
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      historyDelay <= 5'h00;
      cmosDrive    <= 2'h0;
      out1Format   <= 3'h0;
      out2Format   <= 3'h0;
      out1Enabled  <= 1'b0;
      out2Enabled  <= 1'b0;
      out1Cmos     <= 1'b0;
      out2Cmos     <= 1'b0;
    end
    else
    begin
      historyDelay <= methodHistReg[clock_config_pkg::HISTORY_LSB +: 5];
      cmosDrive    <= driveFormatReg[clock_config_pkg::DRIVE_LSB +: 2];
      out1Format   <= driveFormatReg[clock_config_pkg::OUT1_FORMAT_LSB +: 3];
      out2Format   <= driveFormatReg[clock_config_pkg::OUT2_FORMAT_LSB +: 3];
      out1Enabled  <= format_on(driveFormatReg[clock_config_pkg::OUT1_FORMAT_LSB +: 3]);
      out2Enabled  <= format_on(driveFormatReg[clock_config_pkg::OUT2_FORMAT_LSB +: 3]);
      out1Cmos     <= driveFormatReg[clock_config_pkg::OUT1_FORMAT_LSB +: 3] ==
                      clock_config_pkg::FORMAT_CMOS;
      out2Cmos     <= driveFormatReg[clock_config_pkg::OUT2_FORMAT_LSB +: 3] ==
                      clock_config_pkg::FORMAT_CMOS;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence cal_begin;
    calState == clock_config_pkg::CAL_IDLE && calStart;
  endsequence

  sequence cal_busy_two;
    calState == clock_config_pkg::CAL_RUN ##1 calRunning;
  endsequence

  a_bandwidth_apply: assert property (
    $changed(activeBandwidth) |-> $past(calState == clock_config_pkg::CAL_IDLE && calStart))
    else $error("bandwidth changed outside calibration start");
  a_cal_sequence: assert property (cal_begin |=> cal_busy_two)
    else $error("calibration did not start running");
  a_manual_field: assert property (
    methodHistReg[7:6] == 2'h0 && !pickHoldReg[5] && !pinStable[2]
    |=> activeInput == $past(pickHoldReg[7:6]))
    else $error("manual field pick not applied");
  a_pins_pick: assert property (
    methodHistReg[7:6] == 2'h0 && !pickHoldReg[5] && pinStable[2]
    |=> activeInput == $past(pinStable[1:0]))
    else $error("pin pick not applied");
  a_force_hold: assert property (pickHoldReg[5] |=> inHoldover)
    else $error("force holdover ignored");
  a_mute_cal: assert property (
    pickHoldReg[4] && !freeRunCtrl[5] && calState == clock_config_pkg::CAL_RUN |=> !outputsOn)
    else $error("outputs not squelched in calibration");
  a_override_on: assert property (freeRunCtrl[5] |=> outputsOn)
    else $error("override did not unmute outputs");
  a_revert_rank: assert property (
    methodHistReg[7:6] == 2'h2 && !pickHoldReg[5] && inputGood[prioritySlots[1:0]]
    |=> activeInput == $past(prioritySlots[1:0]) && !inHoldover)
    else $error("revertive mode missed first priority input");
  a_reserved_read: assert property (
    regRead && regAddr == 8'h02 |=> regReadData[3:0] == 4'h2)
    else $error("reserved bandwidth bits changed");

endmodule

// >>> sim/clock_select_output_config_regs_bench.sv
// self-checking bench for the clock select and output configuration bank
// assumes the register port is driven directly, one device clock
module clock_select_output_config_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;

  // short calibration keeps the run brief
  localparam int CAL = 4;

  logic       sys_clk;
  logic       rst_b;
  logic [7:0] regAddr;
  logic       regWrite;
  logic [7:0] regWriteData;
  logic       regRead;
  logic [7:0] regReadData;
  logic       calStart;
  logic       pickByPinsPin;
  logic [1:0] inputPickPins;
  logic [3:0] inputGood;
  logic [3:0] activeBandwidth;
  logic       calRunning;
  logic       outputsOn;
  logic [1:0] activeInput;
  logic       inHoldover;
  logic [4:0] historyDelay;
  logic [1:0] cmosDrive;
  logic [2:0] out1Format;
  logic [2:0] out2Format;
  logic       out1Enabled;
  logic       out2Enabled;
  logic       out1Cmos;
  logic       out2Cmos;
  int         nFail;
  int         nTests;
  logic [7:0] d;

  clock_config_regs #(.CAL_CYCLES(CAL)) uut (
    .sys_clk         (sys_clk),
    .rst_b           (rst_b),
    .regAddr         (regAddr),
    .regWrite        (regWrite),
    .regWriteData    (regWriteData),
    .regRead         (regRead),
    .regReadData     (regReadData),
    .calStart        (calStart),
    .pickByPinsPin   (pickByPinsPin),
    .inputPickPins   (inputPickPins),
    .inputGood       (inputGood),
    .activeBandwidth (activeBandwidth),
    .calRunning      (calRunning),
    .outputsOn       (outputsOn),
    .activeInput     (activeInput),
    .inHoldover      (inHoldover),
    .historyDelay    (historyDelay),
    .cmosDrive       (cmosDrive),
    .out1Format      (out1Format),
    .out2Format      (out2Format),
    .out1Enabled     (out1Enabled),
    .out2Enabled     (out2Enabled),
    .out1Cmos        (out1Cmos),
    .out2Cmos        (out2Cmos)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic results();
    if (nFail == 0 && nTests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    nTests++;
    if (got !== exp)
    begin
      nFail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // every task starts and ends just after a rising edge
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    regAddr = a;
    regWriteData = v;
    regWrite = 1'b1;
    idle(1);
    regWrite = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    regAddr = a;
    regRead = 1'b1;
    idle(1);
    regRead = 1'b0;
    idle(1);
    chk($sformatf("reg %h", a), e, regReadData);
  endtask

  task automatic cal();
    calStart = 1'b1;
    idle(1);
    calStart = 1'b0;
  endtask

  task automatic waitCal();
    int i;
    i = 0;
    while (calRunning !== 1'b0 && i < 50)
    begin
      idle(1);
      i++;
    end
    if (i >= 50)
    begin
      nFail++;
      results();
    end
    idle(2);
  endtask

  function automatic logic en(input logic [2:0] f);
    return f inside {3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
  endfunction

  initial
  begin
    nFail = 0;
    nTests = 0;
    rst_b = 1'b0;
    regAddr = 8'h00;
    regWrite = 1'b0;
    regWriteData = 8'h00;
    regRead = 1'b0;
    calStart = 1'b0;
    pickByPinsPin = 1'b0;
    inputPickPins = 2'h0;
    inputGood = 4'hF;
    repeat (12) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    idle(2);
    rd(8'h02, 8'h42);
    rd(8'h03, 8'h05);
    rd(8'h04, 8'h12);
    rd(8'h05, 8'hED);
    chk("historyDelay", 8'h12, {3'h0, historyDelay});
    chk("out1Format", 8'h05, {5'h0, out1Format});
    // reserved bits and an unmapped address
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
    wr(8'h03, 8'h0F);
    rd(8'h03, 8'h05);
    wr(8'h04, 8'h20);
    rd(8'h04, 8'h00);
    wr(8'h02, 8'h7F);
    rd(8'h02, 8'h72);
    idle(3);
    chk("bw before cal", 8'h04, {4'h0, activeBandwidth});
    cal();
    idle(2);
    chk("bw after cal", 8'h07, {4'h0, activeBandwidth});
    chk("calRunning", 8'h01, {7'h0, calRunning});
    chk("on unmuted", 8'h01, {7'h0, outputsOn});
    waitCal();
    wr(8'h03, 8'h1F);
    rd(8'h03, 8'h15);
    cal();
    idle(3);
    chk("on muted", 8'h00, {7'h0, outputsOn});
    waitCal();
    chk("on after", 8'h01, {7'h0, outputsOn});
    wr(8'h00, 8'h20);
    rd(8'h00, 8'h34);
    cal();
    idle(3);
    chk("on override", 8'h01, {7'h0, outputsOn});
    waitCal();
    wr(8'h00, 8'h00);
    idle(1);
    // manual pick by register, then by pins with a clashing field
    wr(8'h04, 8'h0B);
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h03, {k[1:0], 6'h00});
      idle(3);
      chk("pick field", 8'(k), {6'h0, activeInput});
    end
    pickByPinsPin = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      inputPickPins = k[1:0];
      wr(8'h03, {~k[1:0], 6'h00});
      idle(8);
      chk("pick pins", 8'(k), {6'h0, activeInput});
    end
    pickByPinsPin = 1'b0;
    wr(8'h03, 8'h80);
    idle(3);
    wr(8'h03, 8'hE0);
    idle(3);
    chk("hold", 8'h01, {7'h0, inHoldover});
    chk("hold frozen", 8'h02, {6'h0, activeInput});
    wr(8'h03, 8'h80);
    idle(3);
    chk("hold off", 8'h00, {7'h0, inHoldover});
    chk("historyDelay", 8'h0B, {3'h0, historyDelay});
    // automatic methods walk the priority slots
    wr(8'h04, 8'h8B);
    inputGood = 4'hE;
    idle(3);
    chk("revert", 8'h01, {6'h0, activeInput});
    wr(8'h04, 8'h4B);
    inputGood = 4'hF;
    idle(3);
    chk("nonrevert", 8'h01, {6'h0, activeInput});
    wr(8'h04, 8'h8B);
    idle(3);
    chk("revert back", 8'h00, {6'h0, activeInput});
    wr(8'h01, 8'h1B);
    idle(3);
    chk("priority", 8'h03, {6'h0, activeInput});
    inputGood = 4'h0;
    idle(3);
    chk("none good", 8'h01, {7'h0, inHoldover});
    // reserved method freezes hold and input even with good inputs
    wr(8'h04, 8'hCB);
    inputGood = 4'hF;
    idle(3);
    chk("reserved hold", 8'h01, {7'h0, inHoldover});
    chk("reserved input", 8'h03, {6'h0, activeInput});
    // every format code on both outputs, every drive step
    for (int k = 0; k < 8; k++)
    begin
      d = {k[1:0], ~k[2:0], k[2:0]};
      wr(8'h05, d);
      idle(3);
      rd(8'h05, d);
      chk("drive", 8'(k[1:0]), {6'h0, cmosDrive});
      chk("out1Enabled", {7'h0, en(k[2:0])}, {7'h0, out1Enabled});
      chk("out2Enabled", {7'h0, en(~k[2:0])}, {7'h0, out2Enabled});
      chk("out1Cmos", {7'h0, k[2:0] == 3'h2}, {7'h0, out1Cmos});
      chk("out2Cmos", {7'h0, ~k[2:0] == 3'h2}, {7'h0, out2Cmos});
      chk("out2Format", {5'h0, ~k[2:0]}, {5'h0, out2Format});
    end
    results();
  end
endmodule
